/* design/tsio_consts.vh */
/*
 * Constants for the task-state and port-permission block: register offsets,
 * command and status bit positions, task-state block layout and fault limits.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef TSIO_CONSTS_VH
`define TSIO_CONSTS_VH

// ----
// register offsets (byte addresses)
// ----
`define TSIO_OFF_CMD 12'h000
`define TSIO_OFF_MODE 12'h004
`define TSIO_OFF_SEL 12'h008
`define TSIO_OFF_DBASE_LO 12'h00C
`define TSIO_OFF_DBASE_HI 12'h010
`define TSIO_OFF_DLIMIT 12'h014
`define TSIO_OFF_DTYPE 12'h018
`define TSIO_OFF_IOREQ 12'h01C
`define TSIO_OFF_STATUS 12'h020
`define TSIO_OFF_TR_SEL 12'h024
`define TSIO_OFF_TR_BASE_LO 12'h028
`define TSIO_OFF_TR_BASE_HI 12'h02C
`define TSIO_OFF_TR_LIMIT 12'h030
`define TSIO_OFF_TR_TYPE 12'h034
`define TSIO_OFF_CTX 12'h100
`define TSIO_OFF_CTX_END 12'h168

// ----
// command, mode and status bits
// ----
`define TSIO_CMD_LOAD_TR 0
`define TSIO_CMD_SWITCH 1
`define TSIO_CMD_NEST 2
`define TSIO_CMD_IOCHK 3
`define TSIO_CMD_REDIR 4
`define TSIO_MODE_LONG 0
`define TSIO_MODE_64 1
`define TSIO_MODE_V86 2
`define TSIO_ST_BUSY 0
`define TSIO_ST_DONE 1
`define TSIO_ST_GP 2
`define TSIO_ST_TS 3
`define TSIO_ST_DB 4
`define TSIO_ST_GRANT 5
`define TSIO_ST_REDIR 6

// ----
// task-state block layout (dword index = byte offset / 4)
// ----
`define TSIO_CTX_WORDS 26
`define TSIO_IDX_LINK 5'd0
`define TSIO_IDX_DYN_FIRST 5'd8
`define TSIO_IDX_DYN_LAST 5'd22
`define TSIO_IDX_TRAP 5'd25
`define TSIO_OFF_MAPBASE 16'h0066
`define TSIO_MIN_LIMIT 20'h00067
`define TSIO_MAX_MAPBASE 16'hDFFF
`define TSIO_REDIR_BYTES 16'h0020
`define TSIO_TYPE_BUSY 1

`endif

/* design/tsio_core.v */
/*
 * Task-state block loader/saver and port-permission checker with APB registers.
 * Assumes an APB master on i_mclk and a word memory port on the same clock
 * whose i_mem_ack is a one-cycle pulse answering each held o_mem_req.
 */
// Implementation choices: the register addresses and the APB register port.
// Overview of operation
// RULE1: legacy mode ignores upper 32 base bits
// RULE2: 64-bit mode loads full base, compat 8-byte
// RULE3: long mode uses full 64-bit base
// RULE4: software loads 64-bit type in 64-bit mode
// RULE5: load marks busy, no block access, no switch
// RULE6: static fields read on load, never written
// RULE7: dynamic fields read on load, written on suspend
// RULE8: lowest field holds previous task selector
// RULE9: suspend saves six segment selectors (code saves dwords 8 to 22 only, five selectors)
// RULE10: trap bit set raises debug trap on switch
// RULE11: switch touches only first 104 bytes
// RULE12: software keeps critical bytes free of faults
// RULE13: bitmap consulted only in v86 or cpl above threshold
// RULE14: all covering bits clear grants, else fault
// RULE15: 16-bit bitmap base offset from block start
// RULE16: bitmap base above limit faults
// RULE17: read two bitmap bytes per port check
// RULE18: ports beyond segment limit fault
// RULE19: software places bitmap above byte 103
// RULE20: v86 soft interrupts routed by 32-byte map
// RULE21: local table indicator selector faults
// RULE22: limit below minimum raises invalid-state fault
// RULE23: busy type bit; busy target faults
// RULE24: failed check performs no port access
`include "tsio_consts.vh"
`default_nettype none

module tsio_core (
   input wire i_mclk,
   input wire i_reset_n,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   output wire o_mem_req,
   output wire o_mem_we,
   output wire o_mem_half,
   output wire [63:0] o_mem_addr,
   output wire [31:0] o_mem_wdata,
   input wire i_mem_ack,
   input wire [31:0] i_mem_rdata,
   output wire o_mark_busy,
   output wire [15:0] o_mark_busy_sel,
   output wire o_io_grant
);

   // ----
   // states
   // ----
   localparam [5:0] S_IDLE = 6'b000001;
   localparam [5:0] S_SAVE = 6'b000010;
   localparam [5:0] S_LOAD = 6'b000100;
   localparam [5:0] S_LINK = 6'b001000;
   localparam [5:0] S_MAPB = 6'b010000;
   localparam [5:0] S_MAPR = 6'b100000;

   reg [5:0] state_reg;
   reg [31:0] prdata_reg;
   reg pslverr_reg;
   reg [6:0] mode_reg;
   reg [15:0] sel_reg;
   reg [31:0] dbase_lo_reg;
   reg [31:0] dbase_hi_reg;
   reg [19:0] dlimit_reg;
   reg [3:0] dtype_reg;
   reg [15:0] port_reg;
   reg [1:0] size_reg;
   reg [7:0] vec_reg;
   reg [15:0] tr_sel_reg;
   reg [31:0] tr_lo_reg;
   reg [31:0] tr_hi_reg;
   reg [19:0] tr_limit_reg;
   reg [3:0] tr_type_reg;
   reg [15:0] old_sel_reg;
   reg [63:0] old_base_reg;
   reg nest_reg;
   reg redir_op_reg;
   reg [15:0] mapbase_reg;
   reg [4:0] idx_reg;
   reg [6:0] status_reg;
   reg mem_req_reg;
   reg mem_we_reg;
   reg mem_half_reg;
   reg [63:0] mem_addr_reg;
   reg [31:0] mem_wdata_reg;
   reg mark_busy_reg;
   reg io_grant_reg;
   reg [31:0] ctx_mem [0:`TSIO_CTX_WORDS-1];

   wire setup_ph = i_psel & ~i_penable;
   wire wr_acc = i_psel & i_penable & i_pwrite;
   wire [63:0] tr_base = mode_reg[`TSIO_MODE_LONG] ? {tr_hi_reg, tr_lo_reg}
                                                    : {32'h0, tr_lo_reg}; // RULE1 RULE3
   wire [1:0] current_privilege_level = mode_reg[4:3];
   wire [1:0] io_privilege_threshold = mode_reg[6:5];
   wire need_map = mode_reg[`TSIO_MODE_V86] | (current_privilege_level > io_privilege_threshold); // RULE13
   wire ctx_hit = (i_paddr[1:0] == 2'b00) && (i_paddr >= `TSIO_OFF_CTX) &&
                  (i_paddr < `TSIO_OFF_CTX_END);
   wire [4:0] ctx_idx = i_paddr[6:2];
   wire [16:0] bm_byte = {1'b0, mapbase_reg} + {4'h0, port_reg[15:3]};
   wire [16:0] rm_byte = {1'b0, mapbase_reg} - {1'b0, `TSIO_REDIR_BYTES}
                         + {12'h0, vec_reg[7:3]}; // RULE20
   wire [3:0] size_mask = (size_reg == 2'd0) ? 4'h1 :
                          (size_reg == 2'd1) ? 4'h3 : 4'hF;
   wire [15:0] map_half = i_mem_rdata[15:0] >> port_reg[2:0];
   wire [15:0] redir_half = i_mem_rdata[15:0] >> vec_reg[2:0];
   wire is_dyn = (idx_reg == `TSIO_IDX_LINK) ||
                 ((idx_reg >= `TSIO_IDX_DYN_FIRST) && (idx_reg <= `TSIO_IDX_DYN_LAST));

   assign o_prdata = prdata_reg;
   assign o_pready = 1'b1;
   assign o_pslverr = pslverr_reg;
   assign o_mem_req = mem_req_reg;
   assign o_mem_we = mem_we_reg;
   assign o_mem_half = mem_half_reg;
   assign o_mem_addr = mem_addr_reg;
   assign o_mem_wdata = mem_wdata_reg;
   assign o_mark_busy = mark_busy_reg;
   assign o_mark_busy_sel = tr_sel_reg;
   assign o_io_grant = io_grant_reg;

   // ----
   // apb read data, captured in the setup cycle so the access needs no wait
   // ----
   always @(posedge i_mclk) begin
      if (!i_reset_n) begin
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (setup_ph) begin
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         if (ctx_hit) begin
            prdata_reg <= ctx_mem[ctx_idx];
         end else begin
            case (i_paddr)
               `TSIO_OFF_CMD: prdata_reg <= 32'h0;
               `TSIO_OFF_MODE: prdata_reg <= {25'h0, mode_reg};
               `TSIO_OFF_SEL: prdata_reg <= {16'h0, sel_reg};
               `TSIO_OFF_DBASE_LO: prdata_reg <= dbase_lo_reg;
               `TSIO_OFF_DBASE_HI: prdata_reg <= dbase_hi_reg;
               `TSIO_OFF_DLIMIT: prdata_reg <= {12'h0, dlimit_reg};
               `TSIO_OFF_DTYPE: prdata_reg <= {28'h0, dtype_reg};
               `TSIO_OFF_IOREQ: prdata_reg <= {6'h0, size_reg, vec_reg, port_reg};
               `TSIO_OFF_STATUS: prdata_reg <= {25'h0, status_reg};
               `TSIO_OFF_TR_SEL: prdata_reg <= {16'h0, tr_sel_reg};
               `TSIO_OFF_TR_BASE_LO: prdata_reg <= tr_base[31:0];
               `TSIO_OFF_TR_BASE_HI: prdata_reg <= tr_base[63:32];
               `TSIO_OFF_TR_LIMIT: prdata_reg <= {12'h0, tr_limit_reg};
               `TSIO_OFF_TR_TYPE: prdata_reg <= {28'h0, tr_type_reg};
               default: pslverr_reg <= 1'b1;
            endcase
         end
      end
   end

   // ----
   // context image: software fills it, a task load refills it
   // ----
   always @(posedge i_mclk) begin
      if (state_reg == S_LOAD && mem_req_reg && i_mem_ack) begin
         ctx_mem[idx_reg] <= i_mem_rdata; // RULE6 RULE7
      end else if (state_reg == S_IDLE && wr_acc && ctx_hit) begin
         ctx_mem[ctx_idx] <= i_pwdata;
      end
   end

   // ----
   // control registers and sequencer
   // ----
   always @(posedge i_mclk) begin
      if (!i_reset_n) begin
         state_reg <= S_IDLE;
         mode_reg <= 7'h0;
         sel_reg <= 16'h0;
         dbase_lo_reg <= 32'h0;
         dbase_hi_reg <= 32'h0;
         dlimit_reg <= 20'h0;
         dtype_reg <= 4'h0;
         port_reg <= 16'h0;
         size_reg <= 2'd0;
         vec_reg <= 8'h0;
         tr_sel_reg <= 16'h0;
         tr_lo_reg <= 32'h0;
         tr_hi_reg <= 32'h0;
         tr_limit_reg <= 20'h0;
         tr_type_reg <= 4'h0;
         old_sel_reg <= 16'h0;
         old_base_reg <= 64'h0;
         nest_reg <= 1'b0;
         redir_op_reg <= 1'b0;
         mapbase_reg <= 16'h0;
         idx_reg <= 5'd0;
         status_reg <= 7'h0;
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_half_reg <= 1'b0;
         mem_addr_reg <= 64'h0;
         mem_wdata_reg <= 32'h0;
         mark_busy_reg <= 1'b0;
         io_grant_reg <= 1'b0;
      end else begin
         mark_busy_reg <= 1'b0;
         io_grant_reg <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               // writes while busy are dropped so a running sequence sees stable inputs
               if (wr_acc) begin
                  case (i_paddr)
                     `TSIO_OFF_MODE: mode_reg <= i_pwdata[6:0];
                     `TSIO_OFF_SEL: sel_reg <= i_pwdata[15:0];
                     `TSIO_OFF_DBASE_LO: dbase_lo_reg <= i_pwdata;
                     `TSIO_OFF_DBASE_HI: dbase_hi_reg <= i_pwdata;
                     `TSIO_OFF_DLIMIT: dlimit_reg <= i_pwdata[19:0];
                     `TSIO_OFF_DTYPE: dtype_reg <= i_pwdata[3:0];
                     `TSIO_OFF_IOREQ: begin
                        port_reg <= i_pwdata[15:0];
                        vec_reg <= i_pwdata[23:16];
                        size_reg <= i_pwdata[25:24];
                     end
                     default: ;
                  endcase
               end
               if (wr_acc && i_paddr == `TSIO_OFF_CMD) begin
                  status_reg <= 7'h0;
                  nest_reg <= i_pwdata[`TSIO_CMD_NEST];
                  redir_op_reg <= i_pwdata[`TSIO_CMD_REDIR];
                  if (i_pwdata[`TSIO_CMD_LOAD_TR]) begin
                     // load only: no block access, no switch
                     status_reg[`TSIO_ST_DONE] <= 1'b1;
                     if (sel_reg[2] || dtype_reg[`TSIO_TYPE_BUSY]) begin
                        status_reg[`TSIO_ST_GP] <= 1'b1; // RULE21 RULE23
                     end else begin
                        tr_sel_reg <= sel_reg; // RULE5
                        tr_lo_reg <= dbase_lo_reg;
                        // compat mode sees only the 8-byte descriptor form
                        tr_hi_reg <= mode_reg[`TSIO_MODE_64] ? dbase_hi_reg : 32'h0; // RULE2
                        tr_limit_reg <= dlimit_reg;
                        tr_type_reg <= dtype_reg | 4'h2; // RULE5 RULE23
                        mark_busy_reg <= 1'b1; // RULE5
                     end
                  end else if (i_pwdata[`TSIO_CMD_SWITCH]) begin
                     if (sel_reg[2] || dtype_reg[`TSIO_TYPE_BUSY] ||
                         mode_reg[`TSIO_MODE_LONG]) begin
                        status_reg <= 7'h0 | (7'h1 << `TSIO_ST_GP) |
                                      (7'h1 << `TSIO_ST_DONE); // RULE21 RULE23
                     end else if (dlimit_reg < `TSIO_MIN_LIMIT) begin
                        status_reg <= 7'h0 | (7'h1 << `TSIO_ST_TS) |
                                      (7'h1 << `TSIO_ST_DONE); // RULE22
                     end else begin
                        status_reg[`TSIO_ST_BUSY] <= 1'b1;
                        old_sel_reg <= tr_sel_reg;
                        old_base_reg <= tr_base;
                        idx_reg <= `TSIO_IDX_DYN_FIRST;
                        state_reg <= S_SAVE;
                     end
                  end else if (i_pwdata[`TSIO_CMD_IOCHK] || i_pwdata[`TSIO_CMD_REDIR]) begin
                     if (i_pwdata[`TSIO_CMD_IOCHK] && !need_map) begin
                        status_reg[`TSIO_ST_DONE] <= 1'b1; // RULE13
                        status_reg[`TSIO_ST_GRANT] <= 1'b1;
                        io_grant_reg <= 1'b1;
                     end else begin
                        status_reg[`TSIO_ST_BUSY] <= 1'b1;
                        state_reg <= S_MAPB;
                     end
                  end
               end
            end
            S_SAVE: begin
               // suspend: flags, pointer, gprs, five selectors (dwords 8 to 22); static words skipped
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b1;
                  mem_half_reg <= 1'b0;
                  mem_addr_reg <= old_base_reg + {57'h0, idx_reg, 2'b00}; // RULE7 RULE9
                  mem_wdata_reg <= ctx_mem[idx_reg];
               end else if (i_mem_ack) begin
                  mem_req_reg <= 1'b0;
                  mem_we_reg <= 1'b0;
                  if (idx_reg == `TSIO_IDX_DYN_LAST) begin
                     idx_reg <= 5'd0;
                     tr_sel_reg <= sel_reg;
                     tr_lo_reg <= dbase_lo_reg;
                     tr_hi_reg <= 32'h0;
                     tr_limit_reg <= dlimit_reg;
                     tr_type_reg <= dtype_reg | 4'h2; // RULE23
                     mark_busy_reg <= 1'b1;
                     state_reg <= S_LOAD;
                  end else begin
                     idx_reg <= idx_reg + 5'd1;
                  end
               end
            end
            S_LOAD: begin
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_half_reg <= 1'b0;
                  mem_addr_reg <= tr_base + {57'h0, idx_reg, 2'b00}; // RULE11
               end else if (i_mem_ack) begin
                  mem_req_reg <= 1'b0;
                  if (idx_reg == `TSIO_IDX_TRAP) begin
                     mapbase_reg <= i_mem_rdata[31:16]; // RULE15
                     if (i_mem_rdata[0]) begin
                        status_reg[`TSIO_ST_DB] <= 1'b1; // RULE10
                     end
                     if (nest_reg) begin
                        state_reg <= S_LINK;
                     end else begin
                        status_reg[`TSIO_ST_BUSY] <= 1'b0;
                        status_reg[`TSIO_ST_DONE] <= 1'b1;
                        state_reg <= S_IDLE;
                     end
                  end else begin
                     idx_reg <= idx_reg + 5'd1;
                  end
               end
            end
            S_LINK: begin
               // nested entry records the outgoing task in the new block
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b1;
                  mem_half_reg <= 1'b1;
                  mem_addr_reg <= tr_base; // RULE8
                  mem_wdata_reg <= {16'h0, old_sel_reg};
               end else if (i_mem_ack) begin
                  mem_req_reg <= 1'b0;
                  mem_we_reg <= 1'b0;
                  status_reg[`TSIO_ST_BUSY] <= 1'b0;
                  status_reg[`TSIO_ST_DONE] <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            S_MAPB: begin
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_half_reg <= 1'b1;
                  mem_addr_reg <= tr_base + {48'h0, `TSIO_OFF_MAPBASE}; // RULE15
               end else if (i_mem_ack) begin
                  mem_req_reg <= 1'b0;
                  mapbase_reg <= i_mem_rdata[15:0];
                  state_reg <= S_MAPR;
               end
            end
            S_MAPR: begin
               if (!mem_req_reg) begin
                  if (!redir_op_reg && ((mapbase_reg > `TSIO_MAX_MAPBASE) ||
                      ({3'h0, bm_byte} + 20'd1 > tr_limit_reg))) begin
                     // refused before any port access is released
                     status_reg[`TSIO_ST_GP] <= 1'b1; // RULE16 RULE18 RULE24
                     status_reg[`TSIO_ST_BUSY] <= 1'b0;
                     status_reg[`TSIO_ST_DONE] <= 1'b1;
                     state_reg <= S_IDLE;
                  end else begin
                     mem_req_reg <= 1'b1;
                     mem_half_reg <= 1'b1; // RULE17
                     mem_addr_reg <= tr_base + {47'h0, redir_op_reg ? rm_byte : bm_byte};
                  end
               end else if (i_mem_ack) begin
                  mem_req_reg <= 1'b0;
                  status_reg[`TSIO_ST_BUSY] <= 1'b0;
                  status_reg[`TSIO_ST_DONE] <= 1'b1;
                  if (redir_op_reg) begin
                     status_reg[`TSIO_ST_REDIR] <= redir_half[0]; // RULE20
                  end else if ((map_half[3:0] & size_mask) == 4'h0) begin
                     status_reg[`TSIO_ST_GRANT] <= 1'b1; // RULE14
                     io_grant_reg <= 1'b1; // RULE24
                  end else begin
                     status_reg[`TSIO_ST_GP] <= 1'b1; // RULE14
                  end
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

endmodule // tsio_core

`default_nettype wire

/* sim/tsio_core_props.sv */
/* port checker for tsio_core
   assumes one clock, synchronous active-low reset */
`default_nettype none
module tsio_props (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic [63:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic o_mark_busy,
   input wire logic [15:0] o_mark_busy_sel,
   input wire logic o_io_grant
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   wire logic setup = i_psel && !i_penable;
   wire logic mapped = i_paddr[1:0] == 2'h0
      && (i_paddr <= 12'h034 || (i_paddr >= 12'h100 && i_paddr <= 12'h164));
   a_unmapped_err: assert property (setup && !mapped |=> o_pslverr)
      else $error("no error on unmapped address");
   a_mapped_ok: assert property (setup && mapped |=> !o_pslverr)
      else $error("error on mapped address");
   a_cmd_reads_zero: assert property (setup && !i_pwrite && i_paddr == 12'h000
      |=> o_prdata == 32'h0) else $error("command register read not zero");
   a_busy_pulse: assert property (o_mark_busy |=> !o_mark_busy)
      else $error("busy mark longer than one cycle");
   a_grant_pulse: assert property (o_io_grant |=> !o_io_grant)
      else $error("grant longer than one cycle");
   a_load_no_mem: assert property (setup && i_pwrite && i_paddr == 12'h000
      && i_pwdata[0] && !o_mem_req |=> !o_mem_req ##1 !o_mem_req ##1 !o_mem_req)
      else $error("memory touched by pointer load");
   a_busy_sel_gdt: assert property (o_mark_busy |-> !o_mark_busy_sel[2])
      else $error("local table selector marked busy");
   a_req_held: assert property (o_mem_req && !i_mem_ack
      |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
      else $error("memory request changed before ack");
   a_reset_quiet: assert property ($rose(i_reset_n) |-> !o_mem_req && !o_io_grant)
      else $error("outputs active after reset");
endmodule // tsio_props
bind tsio_core tsio_props u_props (.i_mclk, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_prdata, .o_pslverr, .o_mem_req, .o_mem_we, .o_mem_addr, .i_mem_ack,
   .o_mark_busy, .o_mark_busy_sel, .o_io_grant);
`default_nettype wire

/* sim/tsio_mem_model.sv */
/* byte memory partner: acks each request after 0..2 idle cycles
   assumes the core holds a request until its ack */
`default_nettype none
module tsio_mem_model (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic i_half,
   input wire logic [63:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic o_ack = 1'b0,
   output logic [31:0] o_rdata = 32'h5A5A5A5A
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] m [longint unsigned];
   int n_rd = 0;
   int n_wr = 0;
   int turn = 0;
   int waited = 0;
   // unwritten bytes read as ones, so the byte past the map is set whenever left unwritten
   function automatic logic [31:0] rw(input longint unsigned a);
      for (int k = 3; k >= 0; k--) rw = {rw[23:0], m.exists(a + k) ? m[a + k] : 8'hFF};
   endfunction
   // never faults mid-block: every byte is present
   always @(posedge i_mclk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_reset_n && i_req && !o_ack) begin
         if (waited < turn % 3) begin
            waited <= waited + 1;
         end else begin
            waited <= 0;
            turn <= turn + 1;
            o_ack <= 1'b1;
            if (i_we) begin
               n_wr <= n_wr + 1;
               for (int k = 0; k < (i_half ? 2 : 4); k++) m[i_addr + k] = i_wdata[8 * k +: 8];
            end else begin
               n_rd <= n_rd + 1;
               o_rdata <= rw(i_addr) & (i_half ? 32'h0000FFFF : 32'hFFFFFFFF);
            end
         end
      end
   end
endmodule // tsio_mem_model
`default_nettype wire

/* sim/testbench.sv */
/* testbench for tsio_core: apb master, reference sums, memory partner
   assumes zero-wait apb and one command at a time */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] rd;
   logic err;
   logic [15:0] lsel;
   wire logic [31:0] prd, mrd, mwd;
   wire logic prdy, perr, mreq, mwe, mhalf, mack, mbusy, grant;
   wire logic [63:0] maddr;
   wire logic [15:0] bsel;
   integer seed = 32'h8178639f;
   int n_fail = 0;
   int checked = 0;
   int n_grant = 0;
   int n_busy = 0;
   logic [7:0] img [256];
   always #10 i_mclk = ~i_mclk;
   tsio_core dut (.i_mclk, .i_reset_n, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
      .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_half(mhalf), .o_mem_addr(maddr),
      .o_mem_wdata(mwd), .i_mem_ack(mack), .i_mem_rdata(mrd), .o_mark_busy(mbusy),
      .o_mark_busy_sel(bsel), .o_io_grant(grant));
   tsio_mem_model mem (.i_mclk, .i_reset_n, .i_req(mreq), .i_we(mwe), .i_half(mhalf),
      .i_addr(maddr), .i_wdata(mwd), .o_ack(mack), .o_rdata(mrd));
   always @(posedge i_mclk) begin
      if (grant === 1'b1) n_grant <= n_grant + 1;
      if (mbusy === 1'b1) n_busy <= n_busy + 1;
      if (mbusy === 1'b1) lsel <= bsel;
   end
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge i_mclk);
      pen <= 1'b1;
      do @(posedge i_mclk); while (prdy !== 1'b1);
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic desc(input logic [31:0] md, s, lo, hi, lim, ty);
      logic [31:0] v [6];
      v = '{md, s, lo, hi, lim, ty};
      foreach (v[k]) apb(1'b1, 12'(4 * k + 4), v[k]);
   endtask
   // polls until idle; rd then holds the final status
   task automatic cmd(input logic [31:0] c);
      apb(1'b1, 12'h000, c);
      do apb(1'b0, 12'h020, 32'h0); while (rd[0] !== 1'b0);
   endtask
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      logic [31:0] lo, hi, md, v;
      logic [31:0] cx [26];
      logic [31:0] nw [26];
      int mb, lim, port, sz, idx, need, bad, nrd, r0, g0, b0, w0;
      repeat (10) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      apb(1'b0, 12'h020, 32'h0);
      check("status", 0, rd);
      check("slverr", 0, err);
      apb(1'b0, 12'h038, 32'h0);
      check("slverr", 1, err);
      // ----
      // pointer loads: 64-bit, compat, legacy, local table, busy type
      // ----
      for (int i = 0; i < 5; i++) begin
         lo = $random(seed);
         hi = $random(seed) | 32'h1;
         b0 = n_busy;
         w0 = mem.n_rd + mem.n_wr;
         desc(i == 0 ? 3 : i == 1, 32'h18 + 8 * i + (i == 3 ? 4 : 0), lo, hi, 32'h67,
            i == 4 ? 32'hB : 32'h9);
         cmd(32'h1);
         check("load fault", i > 2, rd[2]);
         check("busy marks", i < 3, n_busy - b0);
         check("mem access", 0, mem.n_rd + mem.n_wr - w0);
         v = i < 3 ? 32'h18 + 8 * i : 32'h28;
         check("busy sel", v, lsel);
         apb(1'b0, 12'h024, 32'h0);
         check("task sel", v, rd[15:0]);
         apb(1'b0, 12'h02C, 32'h0);
         check("base hi", i == 0 ? hi : 0, rd);
         if (i == 0) begin
            apb(1'b1, 12'h004, 32'h0);
            apb(1'b0, 12'h02C, 32'h0);
            check("legacy hi", 0, rd);
         end
      end
      // ----
      // port checks and redirect lookups, random privilege and map
      // ----
      for (int i = 0; i < 40; i++) begin
         mb = i == 3 ? 16'hE000 : 16'h0068 + ($random(seed) & 3);
         lim = mb + ($random(seed) & 15);
         md = $random(seed) & 32'h7C;
         port = $random(seed) & 32'h7F;
         sz = ($random(seed) & 32'hFF) % 3;
         v = $random(seed) & 32'hFF;
         foreach (img[k]) img[k] = $random(seed);
         img[8'h66] = mb[7:0];
         img[8'h67] = mb[15:8];
         foreach (img[k]) mem.m[64'h4000 + k] = img[k];
         desc(md, 32'h28, 32'h4000, $random(seed), lim, 32'h9);
         cmd(32'h1);
         apb(1'b1, 12'h01C, port | v << 16 | sz << 24);
         need = md[2] || md[4:3] > md[6:5];
         idx = mb + (port >> 3);
         bad = mb > 16'hDFFF || idx + 1 > lim;
         nrd = !need ? 0 : bad ? 1 : 2;
         bad = need && (bad || (({img[idx + 1], img[idx]} >> port[2:0])
            & ((1 << (1 << sz)) - 1)) != 0);
         r0 = mem.n_rd;
         g0 = n_grant;
         cmd(32'h8);
         check("io fault", bad, rd[2]);
         check("io grant", !bad, rd[5]);
         check("grant pulses", !bad, n_grant - g0);
         check("map reads", nrd, mem.n_rd - r0);
         if (mb < 256) begin
            cmd(32'h10);
            check("redirect", img[mb - 32 + (v >> 3)] >> v[2:0] & 1, rd[6]);
         end
      end
      // ----
      // task switch: refusals, then a nested switch with trap bit
      // ----
      for (int i = 0; i < 2; i++) begin
         w0 = mem.n_wr;
         desc(i == 0, 32'h38, 32'h8000, 32'h0, i ? 32'h66 : 32'h67, 32'h9);
         cmd(32'h2);
         check("switch refused", i ? 32'h8 : 32'h4, rd & 32'h1C);
         check("no writes", 0, mem.n_wr - w0);
      end
      foreach (cx[k]) begin
         cx[k] = $random(seed);
         nw[k] = $random(seed) | (k == 25);
         apb(1'b1, 12'(256 + 4 * k), cx[k]);
         for (int b = 0; b < 4; b++) mem.m[64'h8000 + 4 * k + b] = nw[k][8 * b +: 8];
      end
      w0 = mem.n_wr;
      desc(0, 32'h38, 32'h8000, 32'h0, 32'h67, 32'h9);
      cmd(32'h6);
      check("trap", 32'h10, rd & 32'h1C);
      check("writes", 16, mem.n_wr - w0);
      check("link", 32'h28, mem.rw(64'h8000) & 32'hFFFF);
      foreach (cx[k]) begin
         apb(1'b0, 12'(256 + 4 * k), 32'h0);
         v = mem.rw(64'h4000 + 4 * k);
         if (k > 0) check("ctx load", nw[k], rd);
         if (k > 0 && k < 8) check("static", {img[4*k+3], img[4*k+2], img[4*k+1], img[4*k]}, v);
         if (k > 7 && k < 23) check("saved", cx[k], v);
      end
      report_and_stop;
   end
endmodule // testbench
`default_nettype wire
